// ===== design/iep_pkg.sv
// constants shared by the interrupt enable and priority register block
package iep_pkg;

    // register addresses on the special-function port
    localparam logic [7:0] ADDR_ENABLE_MAIN   = 8'hA8;
    localparam logic [7:0] ADDR_PRIORITY_MAIN = 8'hB8;
    localparam logic [7:0] ADDR_ENABLE_EXT    = 8'hE6;

    // reset values
    localparam logic [7:0] RST_ENABLE_MAIN    = 8'h00;
    localparam logic [7:0] RST_PRIORITY_MAIN  = 8'h80;
    localparam logic [7:0] RST_ENABLE_EXT     = 8'h00;

    // field positions in the main enable register
    localparam int POS_GLOBAL_IRQ_ENABLE      = 7;
    localparam int POS_SYNC_SERIAL            = 6;
    localparam int POS_TIMER2                 = 5;
    localparam int POS_SERIAL_PORT            = 4;
    localparam int POS_TIMER1                 = 3;
    localparam int POS_EXT_IRQ1               = 2;
    localparam int POS_TIMER0                 = 1;
    localparam int POS_EXT_IRQ0               = 0;

    // reserved priority bit, reads as one
    localparam int POS_PRIORITY_RESERVED      = 7;

    // field positions in the extended enable register
    localparam int POS_TIMER3                 = 7;
    localparam int POS_COMPARATOR1            = 6;
    localparam int POS_COMPARATOR0            = 5;
    localparam int POS_COUNTER_ARRAY          = 4;
    localparam int POS_CONVERSION_DONE        = 3;
    localparam int POS_WINDOW_COMPARE         = 2;
    localparam int POS_PIN_MATCH              = 1;
    localparam int POS_TWO_WIRE               = 0;

    // source count and fixed arbitration order, 0 served first
    localparam int NUM_SOURCES                = 15;
    localparam int NUM_MAIN_SOURCES           = 7;
    localparam int SRC_INDEX_W                = 4;

    // bit addresses: base upper five bits, bit number in low three
    localparam int BIT_SEL_W                  = 3;

    // whole state of the block
    typedef struct packed {
        logic [7:0]             en_main;
        logic [6:0]             pri_main;
        logic [7:0]             en_ext;
        logic [NUM_SOURCES-1:0] req;
        logic                   low_busy;
        logic                   high_busy;
        logic                   valid;
        logic [SRC_INDEX_W-1:0] index;
        logic                   high;
        logic [7:0]             rdata;
        logic                   bit_rdata;
    } iep_state_s;

endpackage

// ===== design/iep_first_set.sv
`timescale 1ns/1ns
`default_nettype none
// finds the lowest set bit of a request vector
module iep_first_set #(
    parameter int N = 15,
    parameter int W = 4
) (
    input  wire logic [N-1:0] req_in,
    output logic              found_out,
    output logic [W-1:0]      index_out
);

    // refuse a request count that the index width cannot name
    if (N < 1 || N > (1 << W)) begin : g_bad_size
        $error("iep_first_set: index width too small for N");
    end

    // scan from the top so the lowest index ends up winning
    always_comb begin
        found_out = 1'b0;
        index_out = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (req_in[i]) begin
                found_out = 1'b1;
                index_out = W'(i);
            end
        end
    end

endmodule
`default_nettype wire

// ===== design/iep_irq_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
module iep_irq_ctrl (
    input  wire logic       clk_in,
    input  wire logic       arst_n_in,
    // special-function byte port
    input  wire logic [7:0] sfr_addr_in,
    input  wire logic       sfr_wr_in,
    input  wire logic [7:0] sfr_wdata_in,
    input  wire logic       sfr_rd_in,
    output logic            sfr_hit_out,
    output logic [7:0]      sfr_rdata_out,
    // special-function bit port
    input  wire logic [7:0] bit_addr_in,
    input  wire logic       bit_wr_in,
    input  wire logic       bit_wdata_in,
    input  wire logic       bit_rd_in,
    output logic            bit_hit_out,
    output logic            bit_rdata_out,
    // pending flags from peripherals on this clock
    input  wire logic       ext_irq0_input_in,
    input  wire logic       timer0_overflow_flag_in,
    input  wire logic       ext_irq1_input_in,
    input  wire logic       timer1_overflow_flag_in,
    input  wire logic       serial_port_pending_in,
    input  wire logic       timer2_low_overflow_flag_in,
    input  wire logic       timer2_high_overflow_flag_in,
    input  wire logic       sync_serial_pending_in,
    input  wire logic       two_wire_pending_in,
    input  wire logic       pin_match_pending_in,
    input  wire logic       window_compare_pending_in,
    input  wire logic       conversion_done_pending_in,
    input  wire logic       counter_array_pending_in,
    input  wire logic       comparator0_pending_in,
    input  wire logic       comparator1_pending_in,
    input  wire logic       timer3_low_overflow_flag_in,
    input  wire logic       timer3_high_overflow_flag_in,
    // levels of the eight extended sources, held outside this block
    input  wire logic [7:0] ext_priority_in,
    // core handshake
    input  wire logic       svc_enter_in,
    input  wire logic       svc_return_in,
    output logic            irq_valid_out,
    output logic [3:0]      irq_index_out,
    output logic            irq_high_out,
    output logic [14:0]     irq_req_out,
    output logic [7:0]      irq_enable_main_out,
    output logic [7:0]      irq_priority_main_out,
    output logic [7:0]      irq_enable_extended_out,
    output logic            low_busy_out,
    output logic            high_busy_out
);

    localparam int NS = iep_pkg::NUM_SOURCES;
    localparam int NM = iep_pkg::NUM_MAIN_SOURCES;
    localparam int IW = iep_pkg::SRC_INDEX_W;
    localparam int BW = iep_pkg::BIT_SEL_W;

    iep_pkg::iep_state_s st_reg;
    iep_pkg::iep_state_s st_next;

    logic [NS-1:0] pending;
    logic [NS-1:0] mask_next;
    logic [NS-1:0] level_next;
    logic [NS-1:0] gated_next;
    logic [NS-1:0] high_cand;
    logic [NS-1:0] low_cand;
    logic          global_next;
    logic          high_found;
    logic          low_found;
    logic [IW-1:0] high_index;
    logic [IW-1:0] low_index;
    logic          hit_main;
    logic          hit_pri;
    logic          hit_ext;
    logic          bit_main;
    logic          bit_pri;
    logic [BW-1:0] bit_sel;
    logic [7:0]    en_main_w;
    logic [7:0]    pri_full_w;
    logic [7:0]    en_ext_w;
    logic          allow_high;
    logic          allow_low;

    // pending vector in fixed arbitration order; paired timer flags merge
    assign pending[0]  = ext_irq0_input_in;
    assign pending[1]  = timer0_overflow_flag_in;
    assign pending[2]  = ext_irq1_input_in;
    assign pending[3]  = timer1_overflow_flag_in;
    assign pending[4]  = serial_port_pending_in;
    assign pending[5]  = timer2_low_overflow_flag_in
                       | timer2_high_overflow_flag_in;
    assign pending[6]  = sync_serial_pending_in;
    assign pending[7]  = two_wire_pending_in;
    assign pending[8]  = pin_match_pending_in;
    assign pending[9]  = window_compare_pending_in;
    assign pending[10] = conversion_done_pending_in;
    assign pending[11] = counter_array_pending_in;
    assign pending[12] = comparator0_pending_in;
    assign pending[13] = comparator1_pending_in;
    assign pending[14] = timer3_low_overflow_flag_in
                       | timer3_high_overflow_flag_in;

    // byte address decode
    assign hit_main = (sfr_addr_in == iep_pkg::ADDR_ENABLE_MAIN);
    assign hit_pri  = (sfr_addr_in == iep_pkg::ADDR_PRIORITY_MAIN);
    assign hit_ext  = (sfr_addr_in == iep_pkg::ADDR_ENABLE_EXT);
    assign sfr_hit_out = hit_main | hit_pri | hit_ext;

    // bit address decode; only the main registers are bit-addressable
    assign bit_sel  = bit_addr_in[BW-1:0];
    assign bit_main = (bit_addr_in[7:BW]
                       == iep_pkg::ADDR_ENABLE_MAIN[7:BW]);
    assign bit_pri  = (bit_addr_in[7:BW]
                       == iep_pkg::ADDR_PRIORITY_MAIN[7:BW]);
    assign bit_hit_out = bit_main | bit_pri;

    // register values after this cycle's writes
    always_comb begin
        en_main_w  = st_reg.en_main;
        pri_full_w = {1'b1, st_reg.pri_main};
        en_ext_w   = st_reg.en_ext;
        // whole-byte writes
        if (sfr_wr_in && hit_main) begin
            en_main_w = sfr_wdata_in;
        end
        if (sfr_wr_in && hit_pri) begin
            pri_full_w = sfr_wdata_in;
        end
        if (sfr_wr_in && hit_ext) begin
            en_ext_w = sfr_wdata_in;
        end
        // single-bit writes land on top of any byte write
        if (bit_wr_in && bit_main) begin
            en_main_w[bit_sel] = bit_wdata_in;
        end
        if (bit_wr_in && bit_pri) begin
            pri_full_w[bit_sel] = bit_wdata_in;
        end
        // reserved priority bit never stores
        pri_full_w[iep_pkg::POS_PRIORITY_RESERVED] = 1'b1;
    end

    // per-source masks and levels from the updated registers
    assign global_next = en_main_w[iep_pkg::POS_GLOBAL_IRQ_ENABLE];
    assign mask_next  = {en_ext_w, en_main_w[NM-1:0]};
    assign level_next = {ext_priority_in, pri_full_w[NM-1:0]};

    // gate each pending flag by its own mask and the global enable
    genvar g;
    generate
        for (g = 0; g < NS; g++) begin : gate_gen
            assign gated_next[g] = pending[g] & mask_next[g]
                                 & global_next;
            assign high_cand[g]  = gated_next[g] & level_next[g];
            assign low_cand[g]   = gated_next[g] & ~level_next[g];
        end
    endgenerate

    // lowest index wins within each level
    iep_first_set #(
        .N (NS),
        .W (IW)
    ) u_high_pick (
        .req_in    (high_cand),
        .found_out (high_found),
        .index_out (high_index)
    );

    iep_first_set #(
        .N (NS),
        .W (IW)
    ) u_low_pick (
        .req_in    (low_cand),
        .found_out (low_found),
        .index_out (low_index)
    );

    // preemption: nothing interrupts high service, only high interrupts low
    // busy flags as they stand after this edge's return and entry
    always_comb begin
        allow_high = !(st_reg.high_busy && !svc_return_in)
                     && !(svc_enter_in && st_reg.valid && st_reg.high);
        allow_low  = allow_high
                     && !(st_reg.low_busy
                          && !(svc_return_in && !st_reg.high_busy))
                     && !(svc_enter_in && st_reg.valid && !st_reg.high);
    end

    // next state of the whole block
    always_comb begin
        st_next          = st_reg;
        st_next.en_main  = en_main_w;
        st_next.pri_main = pri_full_w[NM-1:0];
        st_next.en_ext   = en_ext_w;
        st_next.req      = gated_next;
        // a return closes the innermost routine before a new entry
        if (svc_return_in) begin
            if (st_reg.high_busy) begin
                st_next.high_busy = 1'b0;
            end else begin
                st_next.low_busy = 1'b0;
            end
        end
        // the core takes the request presented this cycle
        if (svc_enter_in && st_reg.valid) begin
            if (st_reg.high) begin
                st_next.high_busy = 1'b1;
            end else begin
                st_next.low_busy = 1'b1;
            end
        end
        // high level first, then low, each in fixed order
        st_next.valid = 1'b0;
        st_next.index = '0;
        st_next.high  = 1'b0;
        if (high_found && allow_high) begin
            st_next.valid = 1'b1;
            st_next.index = high_index;
            st_next.high  = 1'b1;
        end else if (low_found && allow_low) begin
            st_next.valid = 1'b1;
            st_next.index = low_index;
        end
        // byte read returns the value held before this cycle's write
        if (sfr_rd_in) begin
            if (hit_main) begin
                st_next.rdata = st_reg.en_main;
            end else if (hit_pri) begin
                st_next.rdata = {1'b1, st_reg.pri_main};
            end else if (hit_ext) begin
                st_next.rdata = st_reg.en_ext;
            end else begin
                st_next.rdata = 8'h00;
            end
        end
        // bit read
        if (bit_rd_in) begin
            if (bit_main) begin
                st_next.bit_rdata = st_reg.en_main[bit_sel];
            end else if (bit_pri) begin
                st_next.bit_rdata = pri_of_bit(st_reg.pri_main, bit_sel);
            end else begin
                st_next.bit_rdata = 1'b0;
            end
        end
    end

    // priority bit lookup with the reserved bit reading one
    function automatic logic pri_of_bit(input logic [6:0]    pri,
                                        input logic [BW-1:0] sel);
        logic [7:0] full;
        full = {1'b1, pri};
        return full[sel];
    endfunction

    // state register
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            st_reg           <= '0;
            st_reg.en_main   <= iep_pkg::RST_ENABLE_MAIN;
            st_reg.pri_main  <= iep_pkg::RST_PRIORITY_MAIN[NM-1:0];
            st_reg.en_ext    <= iep_pkg::RST_ENABLE_EXT;
        end else begin
            st_reg <= st_next;
        end
    end

    // outputs other than the two hit flags, all straight from the state register
    assign irq_valid_out           = st_reg.valid;
    assign irq_index_out           = st_reg.index;
    assign irq_high_out            = st_reg.high;
    assign irq_req_out             = st_reg.req;
    assign irq_enable_main_out     = st_reg.en_main;
    assign irq_priority_main_out   = {1'b1, st_reg.pri_main};
    assign irq_enable_extended_out = st_reg.en_ext;
    assign low_busy_out            = st_reg.low_busy;
    assign high_busy_out           = st_reg.high_busy;
    assign sfr_rdata_out           = st_reg.rdata;
    assign bit_rdata_out           = st_reg.bit_rdata;

endmodule
`default_nettype wire

// ===== dv/iep_irq_chk_assertions.sv
`timescale 1ns/1ns
`default_nettype none
// watches register copies, request gating and service flags of the block
module iep_irq_chk (
    input wire logic        clk_in,
    input wire logic        arst_n_in,
    input wire logic [7:0]  sfr_addr_in,
    input wire logic        sfr_wr_in,
    input wire logic [7:0]  sfr_wdata_in,
    input wire logic        sfr_rd_in,
    input wire logic [7:0]  sfr_rdata_out,
    input wire logic [7:0]  bit_addr_in,
    input wire logic        bit_wr_in,
    input wire logic        bit_wdata_in,
    input wire logic        ext_irq0_input_in,
    input wire logic        timer2_low_overflow_flag_in,
    input wire logic        timer2_high_overflow_flag_in,
    input wire logic        timer3_low_overflow_flag_in,
    input wire logic        timer3_high_overflow_flag_in,
    input wire logic        svc_enter_in,
    input wire logic        svc_return_in,
    input wire logic        irq_valid_out,
    input wire logic [3:0]  irq_index_out,
    input wire logic        irq_high_out,
    input wire logic [14:0] irq_req_out,
    input wire logic [7:0]  irq_enable_main_out,
    input wire logic [7:0]  irq_priority_main_out,
    input wire logic [7:0]  irq_enable_extended_out,
    input wire logic        low_busy_out,
    input wire logic        high_busy_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!arst_n_in);

    // multi-step behaviours
    sequence s_low_take;
        irq_valid_out && !irq_high_out && svc_enter_in && !svc_return_in
            && !low_busy_out && !high_busy_out;
    endsequence
    sequence s_byte_wr_main;
        sfr_wr_in && !bit_wr_in
            && sfr_addr_in == iep_pkg::ADDR_ENABLE_MAIN;
    endsequence

    property p_global_gate;
        irq_req_out != 15'h0000 |-> irq_enable_main_out[7];
    endproperty
    property p_ext0;
        irq_req_out[0] == ($past(ext_irq0_input_in)
            && irq_enable_main_out[7] && irq_enable_main_out[0]);
    endproperty
    property p_timer2;
        irq_req_out[5] == (($past(timer2_low_overflow_flag_in)
            || $past(timer2_high_overflow_flag_in))
            && irq_enable_main_out[7] && irq_enable_main_out[5]);
    endproperty
    property p_timer3;
        irq_req_out[14] == (($past(timer3_low_overflow_flag_in)
            || $past(timer3_high_overflow_flag_in))
            && irq_enable_main_out[7] && irq_enable_extended_out[7]);
    endproperty
    property p_reserved;
        irq_priority_main_out[7];
    endproperty
    property p_present;
        irq_valid_out |-> irq_req_out[irq_index_out];
    endproperty
    property p_high_blocks;
        high_busy_out |-> !irq_valid_out;
    endproperty
    property p_low_preempt;
        low_busy_out && irq_valid_out |-> irq_high_out;
    endproperty
    property p_low_enter;
        s_low_take |=> low_busy_out && !high_busy_out;
    endproperty
    property p_byte_wr;
        s_byte_wr_main |=> irq_enable_main_out == $past(sfr_wdata_in);
    endproperty
    property p_bit_wr;
        bit_wr_in && !sfr_wr_in && bit_addr_in[7:3] == 5'h15 |=>
            irq_enable_main_out[$past(bit_addr_in[2:0])]
                == $past(bit_wdata_in)
            && ((irq_enable_main_out ^ $past(irq_enable_main_out))
            & ~(8'h01 << $past(bit_addr_in[2:0]))) == 8'h00;
    endproperty
    property p_read_pri;
        sfr_rd_in && sfr_addr_in == iep_pkg::ADDR_PRIORITY_MAIN |=>
            sfr_rdata_out == $past(irq_priority_main_out);
    endproperty

    a_global_gate: assert property (p_global_gate)
        else $error("request seen with global enable clear");
    a_ext0: assert property (p_ext0)
        else $error("external 0 request gating wrong");
    a_timer2: assert property (p_timer2)
        else $error("timer 2 request gating wrong");
    a_timer3: assert property (p_timer3)
        else $error("timer 3 request gating wrong");
    a_reserved: assert property (p_reserved)
        else $error("reserved priority bit not one");
    a_present: assert property (p_present)
        else $error("presented source has no gated request");
    a_high_blocks: assert property (p_high_blocks)
        else $error("request presented during high service");
    a_low_preempt: assert property (p_low_preempt)
        else $error("low request presented during low service");
    a_low_enter: assert property (p_low_enter)
        else $error("low service flag not set on entry");
    a_byte_wr: assert property (p_byte_wr)
        else $error("byte write to main enable lost");
    a_bit_wr: assert property (p_bit_wr)
        else $error("bit write touched wrong bits");
    a_read_pri: assert property (p_read_pri)
        else $error("priority read data wrong");
endmodule

bind iep_irq_ctrl iep_irq_chk chk_u (.*);
`default_nettype wire

// ===== dv/iep_core_model.sv
`timescale 1ns/1ns
`default_nettype none
module iep_core_model #(
    parameter int HOLD = 6
) (
    input  wire logic clk_in,
    input  wire logic arst_n_in,
    input  wire logic go_in,
    input  wire logic irq_valid_in,
    output logic      svc_enter_out,
    output logic      svc_return_out
);
    logic [1:0] depth_reg;
    logic [3:0] cnt_reg;
    // take a presented request, leave the innermost routine after HOLD
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            depth_reg      <= 2'h0;
            cnt_reg        <= 4'h0;
            svc_enter_out  <= 1'b0;
            svc_return_out <= 1'b0;
        end else begin
            svc_enter_out  <= 1'b0;
            svc_return_out <= 1'b0;
            cnt_reg        <= cnt_reg + 4'h1;
            if (go_in && irq_valid_in && !svc_enter_out) begin
                svc_enter_out <= 1'b1;
                depth_reg     <= depth_reg + 2'h1;
                cnt_reg       <= 4'h0;
            end else if (depth_reg != 2'h0 && cnt_reg >= 4'(HOLD)) begin
                svc_return_out <= 1'b1;
                depth_reg      <= depth_reg - 2'h1;
                cnt_reg        <= 4'h0;
            end
        end
    end
endmodule
`default_nettype wire

// ===== dv/iep_irq_ctrl_tb.sv
`timescale 1ns/1ns
`default_nettype none
module iep_irq_ctrl_tb;
    logic        clk_in          = 1'b0;
    logic        arst_n_in       = 1'b0;
    logic [7:0]  sfr_addr_in     = 8'h00;
    logic [7:0]  sfr_wdata_in    = 8'h00;
    logic [7:0]  bit_addr_in     = 8'h00;
    logic [7:0]  ext_priority_in = 8'h00;
    logic        sfr_wr_in       = 1'b0;
    logic        sfr_rd_in       = 1'b0;
    logic        bit_wr_in       = 1'b0;
    logic        bit_wdata_in    = 1'b0;
    logic        bit_rd_in       = 1'b0;
    logic        go              = 1'b0;
    logic [16:0] pend            = 17'h00000;
    logic [7:0]  em, pm, ee;
    logic [7:0]  ad [4]          = '{8'hA8, 8'hB8, 8'hE6, 8'h55};
    int          num_errors      = 0;
    int          check_count     = 0;
    wire logic ext_irq0_input_in, timer0_overflow_flag_in, ext_irq1_input_in;
    wire logic timer1_overflow_flag_in, serial_port_pending_in;
    wire logic timer2_low_overflow_flag_in, sync_serial_pending_in;
    wire logic two_wire_pending_in, pin_match_pending_in;
    wire logic window_compare_pending_in, conversion_done_pending_in;
    wire logic counter_array_pending_in, comparator0_pending_in;
    wire logic comparator1_pending_in, timer3_low_overflow_flag_in;
    wire logic timer2_high_overflow_flag_in, timer3_high_overflow_flag_in;
    wire logic svc_enter_in, svc_return_in, sfr_hit_out, bit_hit_out;
    wire logic bit_rdata_out, irq_valid_out, irq_high_out;
    wire logic low_busy_out, high_busy_out;
    wire logic [3:0]  irq_index_out;
    wire logic [14:0] irq_req_out;
    wire logic [7:0]  sfr_rdata_out, irq_enable_main_out;
    wire logic [7:0]  irq_priority_main_out, irq_enable_extended_out;

    // raw flags by source index, timer high halves in the top two bits
    assign {timer3_high_overflow_flag_in, timer2_high_overflow_flag_in,
            timer3_low_overflow_flag_in, comparator1_pending_in,
            comparator0_pending_in, counter_array_pending_in,
            conversion_done_pending_in, window_compare_pending_in,
            pin_match_pending_in, two_wire_pending_in,
            sync_serial_pending_in, timer2_low_overflow_flag_in,
            serial_port_pending_in, timer1_overflow_flag_in,
            ext_irq1_input_in, timer0_overflow_flag_in,
            ext_irq0_input_in} = pend;

    iep_irq_ctrl dut_u (.*);
    iep_core_model core_u (
        .clk_in         (clk_in),
        .arst_n_in      (arst_n_in),
        .go_in          (go),
        .irq_valid_in   (irq_valid_out),
        .svc_enter_out  (svc_enter_in),
        .svc_return_out (svc_return_in)
    );

    // 250 MHz clock
    always #2 clk_in = ~clk_in;

    function automatic logic [14:0] exp_req(logic [16:0] p);
        logic [14:0] s;
        s     = p[14:0];
        s[5]  = p[5] | p[15];
        s[14] = p[14] | p[16];
        return em[7] ? (s & {ee, em[6:0]}) : 15'h0000;
    endfunction

    // higher level first, then lowest source index
    function automatic logic [5:0] exp_pick(logic [14:0] r);
        logic [14:0] lv;
        lv = {ext_priority_in, pm[6:0]};
        for (int h = 1; h >= 0; h--)
            for (int i = 0; i < 15; i++)
                if (r[i] && lv[i] == h[0]) return {1'b1, h[0], 4'(i)};
        return 6'h00;
    endfunction

    task automatic chk(input string nm, input logic [14:0] e,
                       input logic [14:0] g);
        check_count++;
        if (g !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_regs();
        chk("enable main", 15'(em), 15'(irq_enable_main_out));
        chk("priority", 15'(pm), 15'(irq_priority_main_out));
        chk("enable ext", 15'(ee), 15'(irq_enable_extended_out));
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_in);
        sfr_addr_in  = a;
        sfr_wdata_in = d;
        sfr_wr_in    = 1'b1;
        @(negedge clk_in);
        sfr_wr_in    = 1'b0;
        if (a == iep_pkg::ADDR_ENABLE_MAIN) em = d;
        if (a == iep_pkg::ADDR_PRIORITY_MAIN) pm = d | 8'h80;
        if (a == iep_pkg::ADDR_ENABLE_EXT) ee = d;
    endtask

    task automatic rd(input logic [7:0] a);
        logic [7:0] e;
        e = a == 8'hA8 ? em : a == 8'hB8 ? pm : a == 8'hE6 ? ee : 8'h00;
        @(negedge clk_in);
        sfr_addr_in = a;
        sfr_rd_in   = 1'b1;
        @(negedge clk_in);
        sfr_rd_in   = 1'b0;
        chk("byte read", 15'(e), 15'(sfr_rdata_out));
        chk("byte hit", 15'(a inside {8'hA8, 8'hB8, 8'hE6}),
            15'(sfr_hit_out));
    endtask

    task automatic wbit(input logic [7:0] a, input logic v);
        if (a[4] && a[2:0] == 3'h7) v = 1'b1;
        @(negedge clk_in);
        bit_addr_in  = a;
        bit_wdata_in = v;
        bit_wr_in    = 1'b1;
        @(negedge clk_in);
        bit_wr_in    = 1'b0;
        bit_rd_in    = 1'b1;
        @(negedge clk_in);
        bit_rd_in    = 1'b0;
        if (!a[4]) em[a[2:0]] = v;
        if (a[4] && a[2:0] != 3'h7) pm[a[2:0]] = v;
        chk("bit read", 15'(a[4] ? pm[a[2:0]] : em[a[2:0]]),
            15'(bit_rdata_out));
        chk_regs();
        chk("bit hit", 15'h0001, 15'(bit_hit_out));
    endtask

    task automatic end_sim();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // watchdog, well beyond the expected run of under 1000 cycles
    initial begin
        #20000;
        num_errors++;
        end_sim();
    end

    // main sequence
    initial begin
        em = 8'h00;
        pm = 8'h80;
        ee = 8'h00;
        void'($urandom(75807));
        repeat (10) @(posedge clk_in);
        @(negedge clk_in);
        arst_n_in = 1'b1;
        chk_regs();
        for (int i = 0; i < 32; i++) begin
            rd(ad[i % 4]);
            wr(ad[i % 4],
               8'($urandom()) | {i % 4 == 1, 7'h00});
            chk_regs();
        end
        for (int i = 0; i < 32; i++)
            wbit({3'h5, 1'($urandom()), 1'b1, 3'($urandom())},
                 1'($urandom()));
        for (int i = 0; i < 40; i++) begin
            wr(8'hA8, i == 0 ? 8'h7F : i == 1 ? 8'hFF : 8'($urandom()));
            wr(8'hE6, i == 1 ? 8'hFF : 8'($urandom()));
            wr(8'hB8, 8'($urandom()) | 8'h80);
            pend = i < 2 ? 17'h1FFFF : 17'($urandom());
            ext_priority_in = 8'($urandom());
            @(negedge clk_in);
            chk("requests", exp_req(pend),
                irq_req_out);
            chk("presented", 15'(exp_pick(exp_req(pend))),
                15'({irq_valid_out, irq_high_out, irq_index_out}));
        end
        pend = 17'h00000;
        wr(8'hB8, 8'h80);
        wr(8'hA8, 8'hFF);
        pend = 17'h00009;
        go   = 1'b1;
        for (int n = 0; n < 20 && low_busy_out !== 1'b1; n++)
            @(negedge clk_in);
        chk("low entry", 15'h0001, 15'({high_busy_out, low_busy_out}));
        wr(8'hB8, 8'h88);
        for (int n = 0; n < 20 && high_busy_out !== 1'b1; n++)
            @(negedge clk_in);
        chk("preempt", 15'h0003, 15'({high_busy_out, low_busy_out}));
        pend = 17'h00000;
        for (int n = 0; n < 60 && low_busy_out !== 1'b0; n++)
            @(negedge clk_in);
        chk("returned", 15'h0000, 15'({high_busy_out, low_busy_out}));
        end_sim();
    end
endmodule
`default_nettype wire
